// file: cspd_top.sv
// Summary of operation
// - Without wake-up enable, bus activity is masked, receive held recessive, sleep locked.
// - Sleep is left only on enabled bus activity or software clearing sleep request.
// - Clearing sleep request is ignored until sleep request and acknowledge both read one.
// - After any wake-up, eleven consecutive recessive bits are needed before joining traffic.
// - The frame that caused the wake-up is neither received nor stored.
// - Foreground and background receive buffers keep their messages through sleep.
// - Pending buffer move, aborts and queued transmissions run on wake-up.
// - Bus-off count toward 128 recessive sequences continues after sleep, not restarted.
// - Power-down when CPU stops, or waits with halt-in-wait set.
// - Entering power-down stops every transmission and reception at once.
// - Entering power-down forces the transmit output recessive immediately.
// - In power-down clocks are stopped and no register is read or written.
// - Power-down entered while awake runs a fixed recovery delay before normal mode.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`default_nettype none
module cspd_top (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic RECEIVE_LINE_IN,
	output logic TRANSMIT_LINE_OUT,
	output logic RX_INTERNAL,
	input wire logic CORE_TX_BIT,
	input wire logic CORE_BUS_IDLE,
	input wire logic CORE_BUS_OFF,
	input wire logic CORE_RX_VALID,
	input wire logic [31:0] CORE_RX_DATA,
	output logic CORE_ENABLE,
	output logic TX_START,
	output logic ABORT_START,
	output logic BOFF_DONE,
	input wire logic CPU_STOP,
	input wire logic CPU_WAIT,
	output logic CLK_GATE_EN,
	output logic IRQ
);
	typedef struct packed {
		cspd_pkg::cspd_mode_t mode;
		logic sleep_request;
		logic wake_up_enable;
		logic halt_in_wait;
		logic wup_armed;
		logic pd_from_awake;
		logic [15:0] bit_cnt;
		logic [3:0] rec_cnt;
		logic [7:0] boff_cnt;
		logic [15:0] recov_cnt;
		logic [31:0] fg;
		logic [31:0] bg;
		logic fg_v;
		logic bg_v;
		logic abort_pend;
		logic tx_pend;
		logic tx_start;
		logic abort_start;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		logic [31:0] prdata;
	} cspd_state_t;

	cspd_state_t s_q;
	cspd_state_t s_d;
	logic pd;
	logic asleep;
	logic wr;
	logic rd_setup;
	logic bit_tick;
	logic rx_seen;
	logic [31:0] ctrl_rd;
	logic [31:0] stat_rd;

	function automatic logic [31:0] cspd_word(input logic [7:0] v);
		cspd_word = {24'h000000, v};
	endfunction : cspd_word

	////////////////////////////////////////////////////////////////////////////////
	// Power-down decision and bus facing outputs.

	assign pd = CPU_STOP | (CPU_WAIT & s_q.halt_in_wait);
	assign asleep = (s_q.mode == cspd_pkg::ST_SLEEP);
	// Without an armed wake-up the sleeping controller sees an idle bus.
	assign rx_seen = (asleep && !s_q.wup_armed) ? 1'b1 : RECEIVE_LINE_IN;
	assign RX_INTERNAL = rx_seen;
	// The transmit line is recessive unless the controller is fully up; power-down
	// acts combinationally so no dominant bit survives the entry cycle.
	assign TRANSMIT_LINE_OUT = (!pd && s_q.mode == cspd_pkg::ST_NORMAL) ? CORE_TX_BIT : 1'b1;
	assign CORE_ENABLE = !pd && s_q.mode == cspd_pkg::ST_NORMAL;
	assign CLK_GATE_EN = !(pd || s_q.mode == cspd_pkg::ST_PDOWN);
	assign TX_START = s_q.tx_start;
	assign ABORT_START = s_q.abort_start;
	assign BOFF_DONE = (s_q.boff_cnt == cspd_pkg::BOFF_OCCURRENCES);
	assign IRQ = |(s_q.irq_st & s_q.irq_mask);
	assign bit_tick = (s_q.bit_cnt == 16'(cspd_pkg::BIT_CYC - 1));

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: read data is captured in the setup cycle, answer on the first access cycle.

	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && (pd || s_q.mode == cspd_pkg::ST_PDOWN);
	assign PRDATA = s_q.prdata;
	assign wr = PSEL && PENABLE && PWRITE && !PSLVERR;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;

	assign ctrl_rd = cspd_word({5'h00, s_q.halt_in_wait, s_q.wake_up_enable, s_q.sleep_request});
	assign stat_rd = {16'h0000, s_q.boff_cnt, s_q.abort_pend, s_q.tx_pend, s_q.bg_v, s_q.fg_v,
		s_q.mode == cspd_pkg::ST_RECOVER, s_q.mode == cspd_pkg::ST_PDOWN,
		s_q.mode == cspd_pkg::ST_NORMAL, asleep};

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		logic [3:0] ev;
		logic [3:0] w1c;
		logic woke;
		ev = 4'h0;
		w1c = 4'h0;
		woke = 1'b0;
		s_d = s_q;
		s_d.tx_start = 1'b0;
		s_d.abort_start = 1'b0;

		// Bit timer and consecutive recessive bit counter.
		// A completed run of eleven recessive bits starts the count over, so that
		// bus-off recovery sees one occurrence per eleven bits and runs never overlap.
		s_d.bit_cnt = bit_tick ? 16'h0000 : s_q.bit_cnt + 16'h0001;
		if (bit_tick) begin
			if (!rx_seen) begin
				s_d.rec_cnt = 4'h0;
			end else if (s_q.rec_cnt == cspd_cmd_max()) begin
				s_d.rec_cnt = 4'h0;
			end else begin
				s_d.rec_cnt = s_q.rec_cnt + 4'h1;
			end
		end

		// Bus-off recovery count survives sleep and is cleared only when bus-off ends.
		if (!CORE_BUS_OFF) begin
			s_d.boff_cnt = 8'h00;
		end else if (bit_tick && rx_seen && s_q.rec_cnt == cspd_pkg::SYNC_BITS - 4'h1
			&& s_q.boff_cnt != cspd_pkg::BOFF_OCCURRENCES
			&& (s_q.mode == cspd_pkg::ST_NORMAL || s_q.mode == cspd_pkg::ST_SYNC)) begin
			s_d.boff_cnt = s_q.boff_cnt + 8'h01;
		end

		// Register writes.
		if (wr) begin
			unique case (PADDR)
				cspd_pkg::CTRL_OFS: begin
					if (PWDATA[cspd_pkg::CTRL_SLEEP_REQUEST]) begin
						s_d.sleep_request = 1'b1;
					end else if (!s_q.sleep_request || asleep) begin
						s_d.sleep_request = 1'b0;
					end
					s_d.wake_up_enable = PWDATA[cspd_pkg::CTRL_WAKE_UP_ENABLE];
					s_d.halt_in_wait = PWDATA[cspd_pkg::CTRL_HALT_IN_WAIT];
					if (PWDATA[cspd_pkg::CTRL_ABORT]) begin
						s_d.abort_pend = 1'b1;
					end
					if (PWDATA[cspd_pkg::CTRL_TX_QUEUE]) begin
						s_d.tx_pend = 1'b1;
					end
					if (PWDATA[cspd_pkg::CTRL_RX_RELEASE]) begin
						s_d.fg_v = 1'b0;
					end
				end
				cspd_pkg::IRQ_STAT_OFS: w1c = PWDATA[3:0];
				cspd_pkg::IRQ_MASK_OFS: s_d.irq_mask = PWDATA[3:0];
				default: ;
			endcase
		end

		// Mode sequencing.
		unique case (s_q.mode)
			cspd_pkg::ST_NORMAL: begin
				if (pd) begin
					s_d.mode = cspd_pkg::ST_PDOWN;
					s_d.pd_from_awake = 1'b1;
				end else if (s_q.sleep_request && CORE_BUS_IDLE) begin
					s_d.mode = cspd_pkg::ST_SLEEP;
					s_d.wup_armed = s_q.wake_up_enable;
					ev[cspd_pkg::IRQ_SLEEP] = 1'b1;
				end
			end
			cspd_pkg::ST_SLEEP: begin
				if (pd) begin
					s_d.mode = cspd_pkg::ST_PDOWN;
					s_d.pd_from_awake = 1'b0;
				end else if (!s_d.sleep_request) begin
					woke = 1'b1;
				end else if (s_q.wup_armed && !rx_seen) begin
					woke = 1'b1;
					s_d.sleep_request = 1'b0;
				end
				if (woke) begin
					s_d.mode = cspd_pkg::ST_SYNC;
					s_d.rec_cnt = 4'h0;
					s_d.bit_cnt = 16'h0000;
					ev[cspd_pkg::IRQ_WAKE] = 1'b1;
				end
			end
			cspd_pkg::ST_SYNC: begin
				if (pd) begin
					s_d.mode = cspd_pkg::ST_PDOWN;
					s_d.pd_from_awake = 1'b1;
				end else if (bit_tick && rx_seen && s_q.rec_cnt == cspd_pkg::SYNC_BITS - 4'h1) begin
					s_d.mode = cspd_pkg::ST_NORMAL;
				end
			end
			cspd_pkg::ST_PDOWN: begin
				if (!pd) begin
					if (s_q.pd_from_awake) begin
						s_d.mode = cspd_pkg::ST_RECOVER;
						s_d.recov_cnt = 16'h0000;
					end else begin
						s_d.mode = cspd_pkg::ST_SLEEP;
					end
				end
			end
			cspd_pkg::ST_RECOVER: begin
				if (pd) begin
					s_d.mode = cspd_pkg::ST_PDOWN;
				end else if (s_q.recov_cnt == 16'(cspd_pkg::RECOV_CYC - 1)) begin
					s_d.mode = cspd_pkg::ST_SYNC;
					s_d.rec_cnt = 4'h0;
					ev[cspd_pkg::IRQ_RECOVERED] = 1'b1;
				end else begin
					s_d.recov_cnt = s_q.recov_cnt + 16'h0001;
				end
			end
		endcase

		// Message handling runs only while fully up; buffers hold through sleep.
		if (s_q.mode == cspd_pkg::ST_NORMAL && !pd) begin
			if (s_q.bg_v && !s_d.fg_v) begin
				s_d.fg = s_q.bg;
				s_d.fg_v = 1'b1;
				s_d.bg_v = 1'b0;
			end
			if (CORE_RX_VALID && (!s_q.bg_v || !s_d.bg_v)) begin
				s_d.bg = CORE_RX_DATA;
				s_d.bg_v = 1'b1;
				ev[cspd_pkg::IRQ_RX] = 1'b1;
			end
			if (s_d.abort_pend) begin
				s_d.abort_start = 1'b1;
				s_d.abort_pend = 1'b0;
			end
			if (s_d.tx_pend) begin
				s_d.tx_start = 1'b1;
				s_d.tx_pend = 1'b0;
			end
		end

		// Sticky events: a new event wins over a simultaneous clear.
		s_d.irq_st = (s_q.irq_st & ~w1c) | ev;

		// Read data, captured in the setup cycle.
		// The last power-down cycle still counts as power-down, so nothing leaks out.
		if (rd_setup && CLK_GATE_EN) begin
			unique case (PADDR)
				cspd_pkg::CTRL_OFS: s_d.prdata = ctrl_rd;
				cspd_pkg::STAT_OFS: s_d.prdata = stat_rd;
				cspd_pkg::IRQ_STAT_OFS: s_d.prdata = cspd_word({4'h0, s_q.irq_st});
				cspd_pkg::IRQ_MASK_OFS: s_d.prdata = cspd_word({4'h0, s_q.irq_mask});
				cspd_pkg::RX_FG_OFS: s_d.prdata = s_q.fg;
				cspd_pkg::RX_BG_OFS: s_d.prdata = s_q.bg;
				default: s_d.prdata = 32'h00000000;
			endcase
		end else if (rd_setup) begin
			s_d.prdata = 32'h00000000;
		end
	end

	// Last count of a run of recessive bits before the run is complete.
	function automatic logic [3:0] cspd_cmd_max();
		cspd_cmd_max = cspd_pkg::SYNC_BITS - 4'h1;
	endfunction : cspd_cmd_max

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s_q <= '0;
			s_q.mode <= cspd_pkg::ST_NORMAL;
			s_q.irq_mask <= cspd_pkg::IRQ_MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : cspd_top
`default_nettype wire

// file: cspd_pkg.sv
`default_nettype none
package cspd_pkg;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
	localparam logic [7:0] RX_FG_OFS = 8'h10;
	localparam logic [7:0] RX_BG_OFS = 8'h14;
	localparam int CTRL_SLEEP_REQUEST = 0;
	localparam int CTRL_WAKE_UP_ENABLE = 1;
	localparam int CTRL_HALT_IN_WAIT = 2;
	localparam int CTRL_ABORT = 3;
	localparam int CTRL_TX_QUEUE = 4;
	localparam int CTRL_RX_RELEASE = 5;
	localparam int STAT_SLEEP_ACKNOWLEDGE = 0;
	localparam int STAT_SYNCED = 1;
	localparam int STAT_POWER_DOWN = 2;
	localparam int STAT_RECOVERING = 3;
	localparam int STAT_FG_VALID = 4;
	localparam int STAT_BG_VALID = 5;
	localparam int STAT_TX_PEND = 6;
	localparam int STAT_ABORT_PEND = 7;
	localparam int STAT_BOFF_LSB = 8;
	localparam int IRQ_WAKE = 0;
	localparam int IRQ_SLEEP = 1;
	localparam int IRQ_RX = 2;
	localparam int IRQ_RECOVERED = 3;
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_TIME_NS = 1000;
	localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOV_TIME_NS = 2000;
	localparam int RECOV_CYC = (RECOV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SYNC_BITS = 4'hB;
	localparam logic [7:0] BOFF_OCCURRENCES = 8'h80;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_SLEEP,
		ST_SYNC,
		ST_PDOWN,
		ST_RECOVER
	} cspd_mode_t;
endpackage : cspd_pkg
`default_nettype wire

// file: cspd_sva.sv
`default_nettype none
module cspd_sva (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic RECEIVE_LINE_IN,
	input wire logic TRANSMIT_LINE_OUT,
	input wire logic RX_INTERNAL,
	input wire logic CORE_ENABLE,
	input wire logic TX_START,
	input wire logic CPU_STOP,
	input wire logic CPU_WAIT,
	input wire logic CLK_GATE_EN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic [15:0] rec_q;
	// Counts cycles of unbroken recessive level on the bus.
	always_ff @(posedge CLK) begin
		if (!RST_N || !RECEIVE_LINE_IN)
			rec_q <= 16'h0;
		else if (rec_q != 16'hFFFF)
			rec_q <= rec_q + 16'h1;
	end
	sequence s_pd_entry;
		$rose(CPU_STOP);
	endsequence
	sequence s_pd_safe;
		TRANSMIT_LINE_OUT && !CORE_ENABLE && !CLK_GATE_EN;
	endsequence
	AST_PD_ENTRY: assert property (s_pd_entry |-> s_pd_safe)
		else $error("Power-down entry left the engine running.");
	AST_PD_TX: assert property (CPU_STOP |-> TRANSMIT_LINE_OUT)
		else $error("Transmit not recessive in power-down.");
	AST_PD_GATE: assert property (CPU_STOP |-> !CLK_GATE_EN)
		else $error("Clock not gated in power-down.");
	// The gate opens one cycle after stop or wait ends, while the mode leaves power-down.
	AST_GATE_CAUSE: assert property (!CLK_GATE_EN |-> CPU_STOP || CPU_WAIT || $past(CPU_STOP) || $past(CPU_WAIT))
		else $error("Clock gated without stop or wait.");
	AST_PD_ERR: assert property (PSEL && PENABLE && CPU_STOP |-> PSLVERR)
		else $error("Register access in power-down not refused.");
	AST_READY: assert property (PSEL && PENABLE |-> PREADY)
		else $error("Access phase without ready.");
	AST_RX_MASK: assert property (RECEIVE_LINE_IN |-> RX_INTERNAL)
		else $error("Internal receive dominant on a recessive bus.");
	AST_TX_IDLE: assert property (!CORE_ENABLE |-> TRANSMIT_LINE_OUT)
		else $error("Transmit driven while the engine is held.");
	AST_SYNC: assert property ($rose(CORE_ENABLE) |-> rec_q >= 16'h3E0)
		else $error("Joined traffic before eleven recessive bits.");
	AST_PD_NO_TX: assert property (CPU_STOP && $past(CPU_STOP) |-> !TX_START)
		else $error("Transmission launched in power-down.");
endmodule : cspd_sva
bind cspd_top cspd_sva u_sva (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .RECEIVE_LINE_IN(RECEIVE_LINE_IN),
	.TRANSMIT_LINE_OUT(TRANSMIT_LINE_OUT), .RX_INTERNAL(RX_INTERNAL),
	.CORE_ENABLE(CORE_ENABLE), .TX_START(TX_START), .CPU_STOP(CPU_STOP),
	.CPU_WAIT(CPU_WAIT), .CLK_GATE_EN(CLK_GATE_EN));
`default_nettype wire

// file: cspd_can_node.sv
`default_nettype none
module cspd_can_node (
	input wire logic tx_in,
	input wire logic dom,
	output logic rx
);
	timeunit 1ns;
	timeprecision 1ns;
	// The bus is wired-AND: any node sending dominant pulls it low.
	assign rx = tx_in & ~dom;
endmodule : cspd_can_node
`default_nettype wire

// file: can_sleep_power_down_control_tb.sv
`default_nettype none
module can_sleep_power_down_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BC = cspd_pkg::BIT_CYC;
	localparam logic [7:0] CT = cspd_pkg::CTRL_OFS;
	localparam logic [7:0] ST = cspd_pkg::STAT_OFS;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} cspd_row_t;
	cspd_row_t rows [5] = '{'{ST, 32'hFF, 32'h2}, '{8'h18, 32'hFF, 32'h0},
		'{cspd_pkg::RX_FG_OFS, 32'hFF, 32'h0}, '{cspd_pkg::IRQ_STAT_OFS, 32'h0, 32'h0},
		'{cspd_pkg::IRQ_MASK_OFS, 32'h1, 32'h1}};
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rx_line, tx_line, rx_int;
	logic tx_bit, idle, boff, rx_valid, core_en, tx_start, abort_start, boff_done;
	logic stop, wait_i, gate_en, irq, dom, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, rx_data;
	int fail_count = 0;
	int checks_done = 0;
	int n_tx = 0;
	int n_ab = 0;
	logic [7:0] c1;
	cspd_top dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.RECEIVE_LINE_IN(rx_line), .TRANSMIT_LINE_OUT(tx_line), .RX_INTERNAL(rx_int),
		.CORE_TX_BIT(tx_bit), .CORE_BUS_IDLE(idle), .CORE_BUS_OFF(boff),
		.CORE_RX_VALID(rx_valid), .CORE_RX_DATA(rx_data), .CORE_ENABLE(core_en),
		.TX_START(tx_start), .ABORT_START(abort_start), .BOFF_DONE(boff_done),
		.CPU_STOP(stop), .CPU_WAIT(wait_i), .CLK_GATE_EN(gate_en), .IRQ(irq));
	cspd_can_node bus (.tx_in(tx_line), .dom(dom), .rx(rx_line));
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic complete_run;
		$display("Checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	initial begin
		{psel, penable, pwrite, rx_valid, stop, wait_i, dom, boff, rst_n} = 9'h0;
		{tx_bit, idle, paddr, pwdata, rx_data} = {2'h3, 72'h0};
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		foreach (rows[i]) begin
			apb(1'h1, rows[i].a, rows[i].d);
			apb(1'h0, rows[i].a, 32'h0);
			chk("register", rd, rows[i].e);
		end
		rx_valid <= 1'h1;
		rx_data <= 32'hA5A50001;
		@(posedge clk);
		rx_valid <= 1'h0;
		idle <= 1'h0;
		apb(1'h1, CT, 32'h3);
		apb(1'h1, CT, 32'h2);
		apb(1'h0, CT, 32'h0);
		chk("ctrl", rd & 32'h1, 32'h1);
		idle <= 1'h1;
		apb(1'h0, ST, 32'h0);
		chk("ack", rd & 32'h1, 32'h1);
		// A frame arrives while the bus wakes us; it must be dropped.
		dom <= 1'h1;
		rx_valid <= 1'h1;
		@(posedge clk);
		rx_valid <= 1'h0;
		repeat (BC) @(posedge clk);
		dom <= 1'h0;
		apb(1'h0, ST, 32'h0);
		chk("woke", rd & 32'h21, 32'h0);
		chk("irq", {31'h0, irq}, 32'h1);
		repeat (8 * BC) @(posedge clk);
		apb(1'h0, ST, 32'h0);
		chk("early", rd & 32'h2, 32'h0);
		repeat (5 * BC) @(posedge clk);
		apb(1'h0, ST, 32'h0);
		chk("synced", rd & 32'h2, 32'h2);
		apb(1'h0, cspd_pkg::RX_FG_OFS, 32'h0);
		chk("fg", rd, 32'hA5A50001);
		apb(1'h1, cspd_pkg::IRQ_STAT_OFS, 32'hF);
		@(posedge clk);
		chk("irq_clr", {31'h0, irq}, 32'h0);
		// Without wake enable the bus cannot end sleep; software can.
		apb(1'h1, CT, 32'h1);
		dom <= 1'h1;
		repeat (BC) @(posedge clk);
		chk("mask", {31'h0, rx_int}, 32'h1);
		dom <= 1'h0;
		apb(1'h0, ST, 32'h0);
		chk("locked", rd & 32'h1, 32'h1);
		// Abort and transmission queued in sleep wait for the wake-up.
		apb(1'h1, CT, 32'h19);
		apb(1'h0, ST, 32'h0);
		chk("held", rd & 32'hC1, 32'hC1);
		apb(1'h1, CT, 32'h0);
		apb(1'h0, ST, 32'h0);
		chk("sw_wake", rd & 32'h1, 32'h0);
		repeat (13 * BC) begin
			@(posedge clk);
			n_tx += int'(tx_start === 1'h1);
			n_ab += int'(abort_start === 1'h1);
		end
		chk("tx_start", n_tx, 32'h1);
		chk("abort_start", n_ab, 32'h1);
		boff <= 1'h1;
		repeat (12 * BC) @(posedge clk);
		apb(1'h0, ST, 32'h0);
		c1 = rd[15:8];
		chk("boff_cnt", {31'h0, c1 != 8'h00}, 32'h1);
		chk("boff_done", {31'h0, boff_done}, 32'h0);
		// Sleep first, then stop: power-down from sleep returns to sleep.
		apb(1'h1, CT, 32'h1);
		@(posedge clk);
		stop <= 1'h1;
		repeat (2) @(posedge clk);
		stop <= 1'h0;
		apb(1'h0, ST, 32'h0);
		chk("pd_sleep", rd & 32'h9, 32'h1);
		apb(1'h1, CT, 32'h0);
		apb(1'h0, ST, 32'h0);
		chk("boff_kept", {31'h0, rd[15:8] >= c1}, 32'h1);
		repeat (13 * BC) @(posedge clk);
		tx_bit <= 1'h0;
		boff <= 1'h0;
		stop <= 1'h1;
		repeat (2) @(posedge clk);
		chk("tx_pd", {31'h0, tx_line}, 32'h1);
		chk("core_pd", {31'h0, core_en}, 32'h0);
		chk("gate", {31'h0, gate_en}, 32'h0);
		apb(1'h0, ST, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		stop <= 1'h0;
		tx_bit <= 1'h1;
		apb(1'h0, ST, 32'h0);
		chk("recover", rd & 32'h8, 32'h8);
		chk("boff_clr", rd & 32'hFF00, 32'h0);
		repeat (cspd_pkg::RECOV_CYC) @(posedge clk);
		apb(1'h0, ST, 32'h0);
		chk("recovered", rd & 32'h8, 32'h0);
		wait_i <= 1'h1;
		repeat (3) @(posedge clk);
		chk("wait_run", {31'h0, gate_en}, 32'h1);
		wait_i <= 1'h0;
		apb(1'h1, CT, 32'h4);
		wait_i <= 1'h1;
		repeat (3) @(posedge clk);
		chk("wait_halt", {31'h0, gate_en}, 32'h0);
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run();
	end
endmodule : can_sleep_power_down_control_tb
`default_nettype wire
